// ===== include/bp_qual_pkg.sv
// constants and types for the breakpoint qualification unit
package bp_qual_pkg;
    localparam int SLOTS = 8;
    // register byte offsets
    localparam logic [4:0] OFS_SLOT_CMD  = 5'h00;
    localparam logic [4:0] OFS_TRIG_CFG  = 5'h04;
    localparam logic [4:0] OFS_STATUS    = 5'h08;
    localparam logic [4:0] OFS_IRQ_STAT  = 5'h0c;
    localparam logic [4:0] OFS_IRQ_MASK  = 5'h10;
    // slot command fields: [7:0] slot mask, [9:8] action, [16] arm, [17] arm write,
    // [18] opcode select, [19] opcode write
    localparam int SC_ACT_LSB = 8;
    localparam int SC_ARM     = 16;
    localparam int SC_ARM_WR  = 17;
    localparam int SC_OPC     = 18;
    localparam int SC_OPC_WR  = 19;
    // trigger config fields: [15:0] count, [16] rising, [18:17] op
    localparam int TC_RISE    = 16;
    localparam int TC_OP_LSB  = 17;
    // status fields
    localparam int ST_SLOT_LSB = 0;
    localparam int ST_TEN      = 8;
    localparam int ST_TRISE    = 9;
    localparam int ST_TVALID   = 10;
    localparam int ST_ARM      = 11;
    localparam int ST_OPC_LSB  = 16;
    localparam int ST_CNT_LSB  = 24;
    // irq bits
    localparam int IRQ_TRIG = 0;
    localparam int IRQ_EDGE = 1;
    localparam logic [7:0] OPC_HALT   = 8'h76;
    localparam logic [7:0] OPC_LDAA   = 8'h7f;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    // stall held per counted edge, in cycles
    localparam logic [1:0] STALL_CYC  = 2'h2;
    typedef enum logic [1:0] {ACT_NONE, ACT_ON, ACT_OFF, ACT_WIPE} act_t;
    typedef enum logic [1:0] {TOP_EDGE, TOP_ON, TOP_OFF, TOP_WIPE} trig_op_t;
endpackage

// ===== hw/bp_qual_unit.sv
// breakpoint qualification unit with classic wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module bp_qual_unit
    import bp_qual_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        probeIn,
    input  wire logic        emulating,
    input  wire logic        hwBreakAck,
    output logic             haltReq,
    output logic             stallReq,
    output logic [7:0]       slotEnable,
    output logic             breakpointsArmed,
    output logic             hwAllEnable,
    output logic [7:0]       breakOpcode,
    output logic             irq
);
    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // the offset compare is shared by every write strobe
    function automatic logic regHit(input logic [4:0] adr, input logic [4:0] ofs);
        return adr == ofs;
    endfunction

    logic        ack_q;
    // no new access while an answer stands, so one strobe makes exactly one access
    wire         access   = wb_cyc_i && wb_stb_i && !ack_q;
    wire         wrStrobe = access && wb_we_i;
    // a write without every byte lane is answered but changes nothing
    wire         allLanes = &wb_sel_i;
    wire         wrSlot   = wrStrobe && allLanes && regHit(wb_adr_i, OFS_SLOT_CMD);
    wire         wrTrig   = wrStrobe && allLanes && regHit(wb_adr_i, OFS_TRIG_CFG);
    wire         wrIrqSt  = wrStrobe && allLanes && regHit(wb_adr_i, OFS_IRQ_STAT);
    wire         wrIrqMk  = wrStrobe && allLanes && regHit(wb_adr_i, OFS_IRQ_MASK);
    wire [7:0]   slotSel  = wb_dat_i[7:0];
    wire act_t   slotAct  = act_t'(wb_dat_i[SC_ACT_LSB +: 2]);
    wire trig_op_t trigOp = trig_op_t'(wb_dat_i[TC_OP_LSB +: 2]);
    wire [15:0]  cntIn    = wb_dat_i[15:0];

    // ----------------------------------------------------------------
    // slot state
    // ----------------------------------------------------------------
    logic [7:0] slotEn_q, slotEn_d;
    logic       hwEn_q, hwEn_d;
    logic       arm_q;
    logic       opcHalt_q;
    // empty mask means every breakpoint, hardware ones included
    wire        noneNamed = slotSel == 8'h00;
    wire [7:0]  target    = noneNamed ? 8'hff : slotSel;

    always_comb begin
        slotEn_d = slotEn_q;
        hwEn_d   = hwEn_q;
        if (wrSlot && allLanes) begin
            unique case (slotAct)
                ACT_ON:   slotEn_d = slotEn_q | target;
                ACT_OFF:  slotEn_d = slotEn_q & ~target;
                ACT_WIPE: slotEn_d = slotEn_q & ~target;
                ACT_NONE: slotEn_d = slotEn_q;
            endcase
            if (noneNamed && slotAct == ACT_ON) begin
                hwEn_d = 1'b1;
            end else if (noneNamed && slotAct != ACT_NONE) begin
                hwEn_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slotEn_q <= 8'h00;
            hwEn_q   <= 1'b0;
        end else begin
            slotEn_q <= slotEn_d;
            hwEn_q   <= hwEn_d;
        end
    end

    // ----------------------------------------------------------------
    // global arm and break opcode
    // ----------------------------------------------------------------
    // each field has its own write flag, so either can be changed alone
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arm_q <= 1'b0;
        end else if (wrSlot && wb_dat_i[SC_ARM_WR]) begin
            arm_q <= wb_dat_i[SC_ARM];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opcHalt_q <= 1'b0;
        end else if (wrSlot && wb_dat_i[SC_OPC_WR]) begin
            opcHalt_q <= wb_dat_i[SC_OPC];
        end
    end

    // ----------------------------------------------------------------
    // external trigger
    // ----------------------------------------------------------------
    logic        sync1_q, sync2_q, prev_q;
    logic        tEn_q, tRise_q, tValid_q;
    logic [15:0] tCount_q, tRemain_q;
    logic [1:0]  stallCnt_q;
    logic        halt_q;

    // ----------------------------------------------------------------
    // probe synchroniser
    // ----------------------------------------------------------------
    // the edge register reads only the second stage, never the first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= probeIn;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    wire edgeSeen  = tRise_q ? (sync2_q && !prev_q) : (!sync2_q && prev_q);
    wire qualEdge  = edgeSeen && tEn_q && tValid_q && emulating;
    wire lastEdge  = qualEdge && tRemain_q == COUNT_ONE;
    wire trigWr    = wrTrig && allLanes;
    wire reconfig  = trigWr && trigOp == TOP_EDGE;
    wire trigOn    = trigWr && trigOp == TOP_ON;
    wire trigOff   = trigWr && trigOp == TOP_OFF;
    wire trigWipe  = trigWr && trigOp == TOP_WIPE;
    // a zero count is treated as one so the first edge still halts
    wire [15:0] cntLoad = (cntIn == 16'h0000) ? COUNT_ONE : cntIn;

    // ----------------------------------------------------------------
    // trigger specification
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tEn_q <= 1'b0;
        end else if (reconfig) begin
            tEn_q <= 1'b1;
        end else if (trigOn) begin
            // recognition cannot be switched on without an edge setting
            tEn_q <= tValid_q;
        end else if (trigOff || trigWipe) begin
            tEn_q <= 1'b0;
        end
    end

    // off keeps the edge and count; only a wipe returns them to defaults
    always_ff @(posedge clk) begin
        if (sys_rst || trigWipe) begin
            tValid_q <= 1'b0;
            tRise_q  <= 1'b1;
            tCount_q <= COUNT_ONE;
        end else if (reconfig) begin
            tValid_q <= 1'b1;
            tRise_q  <= wb_dat_i[TC_RISE];
            tCount_q <= cntLoad;
        end
    end

    // ----------------------------------------------------------------
    // occurrence counter
    // ----------------------------------------------------------------
    // reloading after a break lets the next run count afresh
    always_ff @(posedge clk) begin
        if (sys_rst || trigWipe) begin
            tRemain_q <= COUNT_ONE;
        end else if (reconfig) begin
            tRemain_q <= cntLoad;
        end else if (lastEdge) begin
            tRemain_q <= tCount_q;
        end else if (qualEdge) begin
            tRemain_q <= tRemain_q - 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // halt and stall requests
    // ----------------------------------------------------------------
    // halt is a level held until the debug core acknowledges the break
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            halt_q <= 1'b0;
        end else if (lastEdge) begin
            halt_q <= 1'b1;
        end else if (hwBreakAck) begin
            halt_q <= 1'b0;
        end
    end

    // a counted edge costs a short stall; the final edge halts instead
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stallCnt_q <= 2'h0;
        end else if (qualEdge && !lastEdge && tCount_q != COUNT_ONE) begin
            stallCnt_q <= STALL_CYC;
        end else if (stallCnt_q != 2'h0) begin
            stallCnt_q <= stallCnt_q - 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    logic [1:0] irqStat_q, irqMask_q;
    wire  [1:0] irqEvt;
    assign irqEvt[IRQ_TRIG] = lastEdge;
    assign irqEvt[IRQ_EDGE] = qualEdge && !lastEdge;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqStat_q <= 2'h0;
            irqMask_q <= 2'h0;
        end else begin
            // a new event wins over a simultaneous clear
            irqStat_q <= (irqStat_q & ~(wrIrqSt ? wb_dat_i[1:0] : 2'h0)) | irqEvt;
            if (wrIrqMk) begin
                irqMask_q <= wb_dat_i[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // read path and outputs
    // ----------------------------------------------------------------
    wire  [7:0]  breakOpcode_d = opcHalt_q ? OPC_HALT : OPC_LDAA;
    logic [31:0] slotWord, trigWord, statusWord, irqStatWord, irqMaskWord, rdData;

    // arm and opcode select read back in the positions of their write flags
    always_comb begin
        slotWord                         = 32'h0000_0000;
        slotWord[ST_SLOT_LSB +: SLOTS]   = slotEn_q;
        slotWord[SC_ARM_WR]              = arm_q;
        slotWord[SC_OPC_WR]              = opcHalt_q;
        trigWord                         = 32'h0000_0000;
        trigWord[15:0]                   = tCount_q;
        trigWord[TC_RISE]                = tRise_q;
        statusWord                       = 32'h0000_0000;
        statusWord[ST_SLOT_LSB +: SLOTS] = slotEn_q;
        statusWord[ST_TEN]               = tEn_q;
        statusWord[ST_TRISE]             = tRise_q;
        statusWord[ST_TVALID]            = tValid_q;
        statusWord[ST_ARM]               = arm_q;
        statusWord[ST_OPC_LSB +: 8]      = breakOpcode_d;
        statusWord[ST_CNT_LSB +: 8]      = tRemain_q[7:0];
        irqStatWord                      = {30'h0, irqStat_q};
        irqMaskWord                      = {30'h0, irqMask_q};
    end

    // unmapped offsets read as zero but are still answered
    always_comb begin
        unique case (wb_adr_i)
            OFS_SLOT_CMD: rdData = slotWord;
            OFS_TRIG_CFG: rdData = trigWord;
            OFS_STATUS:   rdData = statusWord;
            OFS_IRQ_STAT: rdData = irqStatWord;
            OFS_IRQ_MASK: rdData = irqMaskWord;
            default:      rdData = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q            <= 1'b0;
            wb_dat_o         <= 32'h0000_0000;
            haltReq          <= 1'b0;
            stallReq         <= 1'b0;
            slotEnable       <= 8'h00;
            breakpointsArmed <= 1'b0;
            hwAllEnable      <= 1'b0;
            breakOpcode      <= OPC_LDAA;
            irq              <= 1'b0;
        end else begin
            ack_q            <= access;
            wb_dat_o         <= access ? rdData : 32'h0000_0000;
            haltReq          <= halt_q;
            stallReq         <= stallCnt_q != 2'h0;
            // slots only act while the global arm is set
            slotEnable       <= arm_q ? slotEn_q : 8'h00;
            breakpointsArmed <= arm_q;
            hwAllEnable      <= hwEn_q;
            breakOpcode      <= breakOpcode_d;
            irq              <= |(irqStat_q & irqMask_q);
        end
    end
    assign wb_ack_o = ack_q;
endmodule
`default_nettype wire

// ===== verification/bp_qual_unit_monitor.sv
// port-level checks for the breakpoint qualification unit
`timescale 1ns/1ps
`default_nettype none
module bp_qual_unit_monitor (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [4:0] wb_adr_i,
    input wire logic       wb_we_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       probeIn,
    input wire logic       emulating,
    input wire logic       haltReq,
    input wire logic       stallReq,
    input wire logic [7:0] slotEnable,
    input wire logic       breakpointsArmed,
    input wire logic       hwAllEnable,
    input wire logic [7:0] breakOpcode
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus request not acked next cycle");
    property p_gate; !breakpointsArmed |-> slotEnable == 8'h00; endproperty
    a_gate: assert property (p_gate) else $error("slot live while disarmed");
    property p_rst; $fell(sys_rst) |-> !breakpointsArmed && breakOpcode == 8'h7f; endproperty
    a_rst: assert property (p_rst) else $error("wrong state after reset");
    property p_opc; breakOpcode == 8'h76 || breakOpcode == 8'h7f; endproperty
    a_opc: assert property (p_opc) else $error("illegal break opcode");
    property p_emul; $rose(haltReq) |-> $past(emulating, 2); endproperty
    a_emul: assert property (p_emul) else $error("halt outside emulation");
    // an unsynchronised pin would let a halt follow a pin change at once
    property p_sync; $changed(probeIn) |=> !$rose(haltReq) [*2]; endproperty
    a_sync: assert property (p_sync) else $error("halt too soon after pin change");
    property p_stall; $rose(stallReq) |=> stallReq ##1 !stallReq; endproperty
    a_stall: assert property (p_stall) else $error("stall length not two cycles");
    property p_hw; $changed(hwAllEnable) |-> $past(wb_we_i && wb_cyc_i && wb_adr_i == 5'h00);
    endproperty
    a_hw: assert property (p_hw) else $error("hardware enable moved without write");
    property p_slot; $changed(slotEnable) |-> $past(wb_we_i && wb_cyc_i && wb_adr_i == 5'h00);
    endproperty
    a_slot: assert property (p_slot) else $error("slot enables moved without write");
    c_halt: cover property ($rose(haltReq));
    c_stall: cover property ($rose(stallReq));
    c_hw: cover property ($rose(hwAllEnable));
endmodule
`default_nettype wire

// ===== verification/probe_src.sv
// external signal source driving the probe pin
`timescale 1ns/1ps
`default_nettype none
module probe_src (
    input  wire logic clk,
    output var logic  probeIn
);
    initial probeIn = 1'b0;
    // each level is held long enough for sync, edge detect and halt to settle
    task automatic edge_to(input logic v);
        @(posedge clk) probeIn <= v;
        repeat (12) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== verification/bp_qual_unit_tb.sv
// self-checking bench for the breakpoint qualification unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module bp_qual_unit_tb;
    logic        clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        emul = 1'b1, hwAck = 1'b0, mArm = 1'b0, mHw = 1'b0;
    logic        ack, probe, halt, stall, hwAll, armed, irq;
    logic [3:0]  sel = 4'hf;
    logic [4:0]  adr = 5'h00;
    logic [7:0]  slotEn, opc, mEn = 8'h00, mOpc = 8'h7f;
    logic [31:0] wdat = 32'h0, rd, rdat, rv;
    int          error_cnt = 0, cmp_count = 0, cycles = 0, hcnt = 0, scnt = 0;
    integer      seed = 32'heb41d909;
    always #2 clk = ~clk;
    bp_qual_unit bp_qual_unit_inst (.clk(clk), .sys_rst(sys_rst), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .probeIn(probe), .emulating(emul),
        .hwBreakAck(hwAck), .haltReq(halt), .stallReq(stall), .slotEnable(slotEn),
        .breakpointsArmed(armed), .hwAllEnable(hwAll), .breakOpcode(opc), .irq(irq));
    probe_src probe_src_inst (.clk(clk), .probeIn(probe));
    always @(posedge clk) begin
        cycles++;
        if (halt !== 1'b0) hcnt++;
        if (stall !== 1'b0) scnt++;
        if (cycles == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic final_report();
        $display("counts: compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        rd = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic slot(input logic [7:0] m, input logic [1:0] a);
        logic [7:0] k;
        k = (m == 8'h00) ? 8'hff : m;
        wb(5'h00, 1'b1, {22'h0, a, m});
        if (a == 2'd1) mEn = mEn | k;
        else if (a != 2'd0) mEn = mEn & ~k;
        if (m == 8'h00 && a != 2'd0) mHw = (a == 2'd1);
        @(negedge clk);
        `CHK("slotEnable", mArm ? mEn : 8'h00, slotEn)
        `CHK("hwAllEnable", mHw, hwAll)
        `CHK("armed", mArm, armed)
    endtask
    // one edge of polarity r per call, qualifying only while the trigger is on and emulating; the first level change never qualifies
    task automatic occ(input logic r, input int h, input int s);
        probe_src_inst.edge_to(~r);
        hcnt = 0;
        scnt = 0;
        probe_src_inst.edge_to(r);
        `CHK("haltReq", h, int'(hcnt > 0))
        `CHK("stallReq", s, scnt)
        if (hcnt > 0) begin
            hwAck <= 1'b1;
            @(posedge clk) hwAck <= 1'b0;
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        `CHK("breakOpcode", 8'h7f, opc)
        `CHK("armed", 1'b0, armed)
        wb(5'h00, 1'b1, 32'h00030000);
        mArm = 1'b1;
        for (int i = 0; i < 16; i++) begin
            rv = $random(seed);
            slot(rv[12] ? 8'h00 : rv[7:0], rv[9:8]);
        end
        wb(5'h00, 1'b1, 32'h00020000);
        mArm = 1'b0;
        slot(8'h00, 2'd0);
        wb(5'h00, 1'b1, 32'h000f0000);
        {mArm, mOpc} = {1'b1, 8'h76};
        slot(8'h00, 2'd0);
        `CHK("breakOpcode", mOpc, opc)
        wb(5'h08, 1'b0, 32'h0);
        `CHK("status", {8'h0, mOpc, 4'h0, mArm, 3'h0, mEn}, rd & 32'h00ff08ff)
        $display("test slots done");
        wb(5'h04, 1'b1, 32'h00010000);
        wb(5'h08, 1'b0, 32'h0);
        `CHK("trigState", 3'b111, rd[10:8])
        occ(1'b1, 1, 0);
        wb(5'h04, 1'b1, 32'h00000003);
        for (int i = 0; i < 2; i++) begin
            occ(1'b0, 0, 2);
            occ(1'b0, 0, 2);
            occ(1'b0, 1, 0);
        end
        wb(5'h04, 1'b1, 32'h00040000);
        wb(5'h08, 1'b0, 32'h0);
        `CHK("trigState", 3'b100, rd[10:8])
        occ(1'b0, 0, 0);
        wb(5'h04, 1'b1, 32'h00020000);
        emul <= 1'b0;
        occ(1'b0, 0, 0);
        emul <= 1'b1;
        $display("test trigger done");
        wb(5'h10, 1'b1, 32'h00000001);
        @(negedge clk);
        `CHK("irq", 1'b1, irq)
        wb(5'h0c, 1'b1, 32'h00000003);
        @(negedge clk);
        `CHK("irq", 1'b0, irq)
        wb(5'h04, 1'b1, 32'h00000001);
        occ(1'b0, 1, 0);
        `CHK("irq", 1'b1, irq)
        wb(5'h04, 1'b1, 32'h00060000);
        wb(5'h08, 1'b0, 32'h0);
        `CHK("trigValid", 1'b0, rd[10])
        wb(5'h14, 1'b0, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        sel <= 4'h3;
        wb(5'h00, 1'b1, 32'h00000300);
        sel <= 4'hf;
        slot(8'h00, 2'd0);
        $display("test irq and refusal done");
        final_report();
    end
endmodule
bind bp_qual_unit bp_qual_unit_monitor mon_inst (.clk(clk), .sys_rst(sys_rst),
    .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .probeIn(probeIn), .emulating(emulating), .haltReq(haltReq),
    .stallReq(stallReq), .slotEnable(slotEnable), .breakpointsArmed(breakpointsArmed),
    .hwAllEnable(hwAllEnable), .breakOpcode(breakOpcode));
`default_nettype wire
